// [dafrb_pkg.sv]
// package: register map, field positions and reset values of the feature register bank
package dafrb_pkg;
  localparam int unsigned ADDR_W = 9;

  // register offsets
  localparam logic [8:0] OFS_PATT1_HI   = 9'h01a;
  localparam logic [8:0] OFS_PATT2_LO   = 9'h01b;
  localparam logic [8:0] OFS_PATT2_HI   = 9'h01c;
  localparam logic [8:0] OFS_SIG_LO     = 9'h024;
  localparam logic [8:0] OFS_OVR_FEAT   = 9'h02a;
  localparam logic [8:0] OFS_OUT_ASSIGN = 9'h02e;
  localparam logic [8:0] OFS_SYNC_CTRL  = 9'h100;
  localparam logic [8:0] OFS_USER_OPT2  = 9'h101;
  localparam logic [8:0] OFS_QEC_CTRL_A = 9'h110;
  localparam logic [8:0] OFS_QEC_CTRL_B = 9'h111;
  localparam logic [8:0] OFS_GAIN_BW    = 9'h112;
  localparam logic [8:0] OFS_PHASE_BW   = 9'h113;
  localparam logic [8:0] OFS_DC_BW      = 9'h114;
  localparam logic [8:0] OFS_GAIN_LO    = 9'h116;
  localparam logic [8:0] OFS_GAIN_HI    = 9'h117;
  localparam logic [8:0] OFS_PHASE_LO   = 9'h118;
  localparam logic [8:0] OFS_PHASE_HI   = 9'h119;
  localparam logic [8:0] OFS_DCI_LO     = 9'h11a;
  localparam logic [8:0] OFS_DCI_HI     = 9'h11b;
  localparam logic [8:0] OFS_DCQ_LO     = 9'h11c;
  localparam logic [8:0] OFS_DCQ_HI     = 9'h11d;
  localparam logic [8:0] OFS_NSR_CTRL   = 9'h11e;

  // writable-bit masks, unused bits read zero
  localparam logic [7:0] MSK_FULL   = 8'hff;
  localparam logic [7:0] MSK_BIT0   = 8'h01;
  localparam logic [7:0] MSK_SYNC   = 8'h07;
  localparam logic [7:0] MSK_USER_OPTIONS_TWO   = 8'h8d;
  localparam logic [7:0] MSK_QEC_A  = 8'h3f;
  localparam logic [7:0] MSK_QEC_B  = 8'h07;
  localparam logic [7:0] MSK_BW     = 8'h1f;
  localparam logic [7:0] MSK_GAIN_H = 8'h7f;
  localparam logic [7:0] MSK_PHAS_H = 8'h1f;
  localparam logic [7:0] MSK_DC_H   = 8'h3f;
  localparam logic [7:0] MSK_NSR    = 8'h07;

  // reset values
  localparam logic [7:0] RST_ZERO     = 8'h00;
  localparam logic [7:0] RST_OVR_FEAT = 8'h01;
  localparam logic [7:0] RST_ASSIGN_A = 8'h00;
  localparam logic [7:0] RST_ASSIGN_B = 8'h01;
  localparam logic [7:0] RST_SYNC     = 8'h01;
  localparam logic [7:0] RST_USER_OPTIONS_TWO     = 8'h88;
  localparam logic [7:0] RST_BW       = 8'h02;

  // field positions
  localparam int unsigned BIT_MASTER_SYNC = 0;
  localparam int unsigned BIT_DIV_SYNC    = 1;
  localparam int unsigned BIT_NEXT_SYNC   = 2;
  localparam int unsigned BIT_PULLDN_DIS  = 0;
  localparam int unsigned BIT_RUN_OSC     = 2;
  localparam int unsigned BIT_DETECT_EN   = 3;
  localparam int unsigned BIT_OE_PIN_EN   = 7;
  localparam int unsigned BIT_FORCE_GAIN  = 0;
  localparam int unsigned BIT_FORCE_PHASE = 1;
  localparam int unsigned BIT_FORCE_DC    = 2;
  localparam int unsigned BIT_NSR_ON      = 0;

  // noise shaping modes
  typedef enum logic [1:0] {
    DAFRB_NS_LOW_PASS  = 2'b00,
    DAFRB_NS_HIGH_PASS = 2'b01,
    DAFRB_NS_BAND_PASS = 2'b10
  } dafrb_ns_mode_t;
endpackage

// [dafrb_sync_gate.sv]
// sync pulse gating toward the clock divider, with one-shot mode
`timescale 1ns/1ps
module dafrb_sync_gate (
  // clock and reset
  input  wire logic i_clk_sys,
  input  wire logic i_rst_n,
  // settings
  input  wire logic i_master_en,
  input  wire logic i_div_en,
  input  wire logic i_next_only,
  // sync pulse, already synchronised
  input  wire logic i_sync_pulse,
  // outputs
  output logic      o_div_sync,
  output logic      o_clear_div_en
);
  logic div_sync_reg;
  logic div_sync_next;

  // gate only when master and divider enable both high
  always_comb begin
    div_sync_next = i_sync_pulse & i_master_en & i_div_en;
  end

  always_ff @(posedge i_clk_sys or negedge i_rst_n) begin
    if (!i_rst_n) begin
      div_sync_reg <= 1'b0;
    end else begin
      div_sync_reg <= div_sync_next;
    end
  end

  assign o_div_sync     = div_sync_reg;
  // one-shot: drop the divider enable after the first pulse
  assign o_clear_div_en = div_sync_next & i_next_only;
endmodule // dafrb_sync_gate

// [dafrb_regs.sv]
// top: dual converter feature register bank behind the serial control port
// Contract
// - output assign bit picks converter A/B
// - overrange pin enable bit, resets enabled
// - 14-bit in-phase dc initial value
// - 14-bit quadrature dc initial value
// - force dc applies stored dc values; here the stored dc values drive out whatever force dc is
// - noise shaping mode and enable bit
// - sync acts only with master enable
// - rate detect enables fallback oscillator
`timescale 1ns/1ps
module dafrb_regs (
  // clock and reset
  input  wire logic                          i_clk_sys,
  input  wire logic                          i_arst_n,
  // register port from the serial decoder
  input  wire logic                          i_wr_en,
  input  wire logic                          i_rd_en,
  input  wire logic [dafrb_pkg::ADDR_W-1:0]  i_addr,
  input  wire logic [7:0]                    i_wdata,
  input  wire logic                          i_chan_sel_a,
  input  wire logic                          i_chan_sel_b,
  output logic [7:0]                         o_rdata,
  output logic                               o_rvalid,
  // device status inputs
  input  wire logic [7:0]                    i_signature_lo,
  input  wire logic                          i_low_rate_pin,
  input  wire logic                          i_sync_pin,
  // converter and pin controls
  output logic                               o_assign_a,
  output logic                               o_assign_b,
  output logic                               o_overrange_indication_pin_oe_a,
  output logic                               o_overrange_indication_pin_oe_b,
  output logic                               o_output_enable_pin_en,
  output logic                               o_sdio_pulldown_dis,
  output logic                               o_fallback_oscillator_en,
  output logic                               o_div_sync,
  // pattern words
  output logic [15:0]                        o_patt1_hi_byte,
  output logic [15:0]                        o_patt2,
  // correction controls
  output logic [5:0]                         o_qec_ctrl,
  output logic [2:0]                         o_qec_force,
  output logic [4:0]                         o_gain_bw,
  output logic [4:0]                         o_phase_bw,
  output logic [4:0]                         o_dc_loop_time_constant,
  output logic [14:0]                        o_gain_value,
  output logic [12:0]                        o_phase_value,
  output logic                               o_dc_force,
  output logic [13:0]                        o_dc_inphase,
  output logic [13:0]                        o_dc_quadrature,
  // requantizer
  output logic                               o_nsr_on,
  output logic [1:0]                         o_nsr_mode
);
  import dafrb_pkg::*;

  // reset release and pin synchronisers
  logic [1:0] rst_sync_reg;
  logic       rst_n;
  logic [1:0] low_rate_sync_reg;
  logic [1:0] sync_pin_reg;
  logic       sync_prev_reg;
  logic       sync_pulse;

  always_ff @(posedge i_clk_sys or negedge i_arst_n) begin
    if (!i_arst_n) begin
      rst_sync_reg <= 2'b00;
    end else begin
      rst_sync_reg <= {rst_sync_reg[0], 1'b1};
    end
  end
  assign rst_n = rst_sync_reg[1];

  // pins from outside pass two flops before use
  always_ff @(posedge i_clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      low_rate_sync_reg <= 2'b00;
      sync_pin_reg      <= 2'b00;
      sync_prev_reg     <= 1'b0;
    end else begin
      low_rate_sync_reg <= {low_rate_sync_reg[0], i_low_rate_pin};
      sync_pin_reg      <= {sync_pin_reg[0], i_sync_pin};
      sync_prev_reg     <= sync_pin_reg[1];
    end
  end
  assign sync_pulse = sync_pin_reg[1] & ~sync_prev_reg;

  // register storage
  logic [7:0] patt1_hi_reg, patt2_lo_reg, patt2_hi_reg;
  logic [7:0] ovr_a_reg, ovr_b_reg, asg_a_reg, asg_b_reg;
  logic [7:0] sync_reg, user_options_two_reg, qa_reg, qb_reg;
  logic [7:0] gbw_reg, pbw_reg, dbw_reg;
  logic [7:0] g_lo_reg, g_hi_reg, p_lo_reg, p_hi_reg;
  logic [7:0] dci_lo_reg, dci_hi_reg, dcq_lo_reg, dcq_hi_reg, nsr_reg;
  logic [7:0] patt1_hi_next, patt2_lo_next, patt2_hi_next;
  logic [7:0] ovr_a_next, ovr_b_next, asg_a_next, asg_b_next;
  logic [7:0] sync_next, user_options_two_next, qa_next, qb_next;
  logic [7:0] gbw_next, pbw_next, dbw_next;
  logic [7:0] g_lo_next, g_hi_next, p_lo_next, p_hi_next;
  logic [7:0] dci_lo_next, dci_hi_next, dcq_lo_next, dcq_hi_next, nsr_next;
  logic [7:0] rdata_reg, rdata_next;
  logic       rvalid_reg;
  logic       clear_div_en;

  // masked write: unused bits stay zero
  function automatic logic [7:0] wr_field(input logic hit, input logic [7:0] cur,
                                          input logic [7:0] wd, input logic [7:0] msk);
    wr_field = hit ? (wd & msk) : cur;
  endfunction

  // next-state for every register
  always_comb begin
    patt1_hi_next = wr_field(i_wr_en && i_addr == OFS_PATT1_HI, patt1_hi_reg, i_wdata, MSK_FULL);
    patt2_lo_next = wr_field(i_wr_en && i_addr == OFS_PATT2_LO, patt2_lo_reg, i_wdata, MSK_FULL);
    patt2_hi_next = wr_field(i_wr_en && i_addr == OFS_PATT2_HI, patt2_hi_reg, i_wdata, MSK_FULL);
    ovr_a_next = wr_field(i_wr_en && i_chan_sel_a && i_addr == OFS_OVR_FEAT, ovr_a_reg, i_wdata, MSK_BIT0);
    ovr_b_next = wr_field(i_wr_en && i_chan_sel_b && i_addr == OFS_OVR_FEAT, ovr_b_reg, i_wdata, MSK_BIT0);
    asg_a_next = wr_field(i_wr_en && i_chan_sel_a && i_addr == OFS_OUT_ASSIGN, asg_a_reg, i_wdata, MSK_BIT0);
    asg_b_next = wr_field(i_wr_en && i_chan_sel_b && i_addr == OFS_OUT_ASSIGN, asg_b_reg, i_wdata, MSK_BIT0);
    sync_next = wr_field(i_wr_en && i_addr == OFS_SYNC_CTRL, sync_reg, i_wdata, MSK_SYNC);
    // one-shot self-clear wins only when no write this cycle
    if (clear_div_en && !(i_wr_en && i_addr == OFS_SYNC_CTRL)) begin
      sync_next[BIT_DIV_SYNC] = 1'b0;
    end
    user_options_two_next   = wr_field(i_wr_en && i_addr == OFS_USER_OPT2, user_options_two_reg, i_wdata, MSK_USER_OPTIONS_TWO);
    qa_next     = wr_field(i_wr_en && i_addr == OFS_QEC_CTRL_A, qa_reg, i_wdata, MSK_QEC_A);
    qb_next     = wr_field(i_wr_en && i_addr == OFS_QEC_CTRL_B, qb_reg, i_wdata, MSK_QEC_B);
    gbw_next    = wr_field(i_wr_en && i_addr == OFS_GAIN_BW, gbw_reg, i_wdata, MSK_BW);
    pbw_next    = wr_field(i_wr_en && i_addr == OFS_PHASE_BW, pbw_reg, i_wdata, MSK_BW);
    dbw_next    = wr_field(i_wr_en && i_addr == OFS_DC_BW, dbw_reg, i_wdata, MSK_BW);
    g_lo_next   = wr_field(i_wr_en && i_addr == OFS_GAIN_LO, g_lo_reg, i_wdata, MSK_FULL);
    g_hi_next   = wr_field(i_wr_en && i_addr == OFS_GAIN_HI, g_hi_reg, i_wdata, MSK_GAIN_H);
    p_lo_next   = wr_field(i_wr_en && i_addr == OFS_PHASE_LO, p_lo_reg, i_wdata, MSK_FULL);
    p_hi_next   = wr_field(i_wr_en && i_addr == OFS_PHASE_HI, p_hi_reg, i_wdata, MSK_PHAS_H);
    dci_lo_next = wr_field(i_wr_en && i_addr == OFS_DCI_LO, dci_lo_reg, i_wdata, MSK_FULL);
    dci_hi_next = wr_field(i_wr_en && i_addr == OFS_DCI_HI, dci_hi_reg, i_wdata, MSK_DC_H);
    dcq_lo_next = wr_field(i_wr_en && i_addr == OFS_DCQ_LO, dcq_lo_reg, i_wdata, MSK_FULL);
    dcq_hi_next = wr_field(i_wr_en && i_addr == OFS_DCQ_HI, dcq_hi_reg, i_wdata, MSK_DC_H);
    nsr_next    = wr_field(i_wr_en && i_addr == OFS_NSR_CTRL, nsr_reg, i_wdata, MSK_NSR);
  end

  // read mux; channel A wins if both selected, unmapped reads zero
  always_comb begin
    rdata_next = rdata_reg;
    if (i_rd_en) begin
      unique case (i_addr)
        OFS_PATT1_HI:   rdata_next = patt1_hi_reg;
        OFS_PATT2_LO:   rdata_next = patt2_lo_reg;
        OFS_PATT2_HI:   rdata_next = patt2_hi_reg;
        OFS_SIG_LO:     rdata_next = i_signature_lo;
        OFS_OVR_FEAT:   rdata_next = i_chan_sel_a ? ovr_a_reg : ovr_b_reg;
        OFS_OUT_ASSIGN: rdata_next = i_chan_sel_a ? asg_a_reg : asg_b_reg;
        OFS_SYNC_CTRL:  rdata_next = sync_reg;
        OFS_USER_OPT2:  rdata_next = user_options_two_reg;
        OFS_QEC_CTRL_A: rdata_next = qa_reg;
        OFS_QEC_CTRL_B: rdata_next = qb_reg;
        OFS_GAIN_BW:    rdata_next = gbw_reg;
        OFS_PHASE_BW:   rdata_next = pbw_reg;
        OFS_DC_BW:      rdata_next = dbw_reg;
        OFS_GAIN_LO:    rdata_next = g_lo_reg;
        OFS_GAIN_HI:    rdata_next = g_hi_reg;
        OFS_PHASE_LO:   rdata_next = p_lo_reg;
        OFS_PHASE_HI:   rdata_next = p_hi_reg;
        OFS_DCI_LO:     rdata_next = dci_lo_reg;
        OFS_DCI_HI:     rdata_next = dci_hi_reg;
        OFS_DCQ_LO:     rdata_next = dcq_lo_reg;
        OFS_DCQ_HI:     rdata_next = dcq_hi_reg;
        OFS_NSR_CTRL:   rdata_next = nsr_reg;
        default:        rdata_next = RST_ZERO;
      endcase
    end
  end

  // registers take the printed defaults at reset
  always_ff @(posedge i_clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      patt1_hi_reg <= RST_ZERO;
      patt2_lo_reg <= RST_ZERO;
      patt2_hi_reg <= RST_ZERO;
      ovr_a_reg    <= RST_OVR_FEAT;
      ovr_b_reg    <= RST_OVR_FEAT;
      asg_a_reg    <= RST_ASSIGN_A;
      asg_b_reg    <= RST_ASSIGN_B;
      sync_reg     <= RST_SYNC;
      user_options_two_reg     <= RST_USER_OPTIONS_TWO;
      qa_reg       <= RST_ZERO;
      qb_reg       <= RST_ZERO;
      gbw_reg      <= RST_BW;
      pbw_reg      <= RST_BW;
      dbw_reg      <= RST_BW;
      g_lo_reg     <= RST_ZERO;
      g_hi_reg     <= RST_ZERO;
      p_lo_reg     <= RST_ZERO;
      p_hi_reg     <= RST_ZERO;
      dci_lo_reg   <= RST_ZERO;
      dci_hi_reg   <= RST_ZERO;
      dcq_lo_reg   <= RST_ZERO;
      dcq_hi_reg   <= RST_ZERO;
      nsr_reg      <= RST_ZERO;
      rdata_reg    <= RST_ZERO;
      rvalid_reg   <= 1'b0;
    end else begin
      patt1_hi_reg <= patt1_hi_next;
      patt2_lo_reg <= patt2_lo_next;
      patt2_hi_reg <= patt2_hi_next;
      ovr_a_reg    <= ovr_a_next;
      ovr_b_reg    <= ovr_b_next;
      asg_a_reg    <= asg_a_next;
      asg_b_reg    <= asg_b_next;
      sync_reg     <= sync_next;
      user_options_two_reg     <= user_options_two_next;
      qa_reg       <= qa_next;
      qb_reg       <= qb_next;
      gbw_reg      <= gbw_next;
      pbw_reg      <= pbw_next;
      dbw_reg      <= dbw_next;
      g_lo_reg     <= g_lo_next;
      g_hi_reg     <= g_hi_next;
      p_lo_reg     <= p_lo_next;
      p_hi_reg     <= p_hi_next;
      dci_lo_reg   <= dci_lo_next;
      dci_hi_reg   <= dci_hi_next;
      dcq_lo_reg   <= dcq_lo_next;
      dcq_hi_reg   <= dcq_hi_next;
      nsr_reg      <= nsr_next;
      rdata_reg    <= rdata_next;
      rvalid_reg   <= i_rd_en;
    end
  end

  dafrb_sync_gate u_sync_gate (
    .i_clk_sys      (i_clk_sys),
    .i_rst_n        (rst_n),
    .i_master_en    (sync_reg[BIT_MASTER_SYNC]),
    .i_div_en       (sync_reg[BIT_DIV_SYNC]),
    .i_next_only    (sync_reg[BIT_NEXT_SYNC]),
    .i_sync_pulse   (sync_pulse),
    .o_div_sync     (o_div_sync),
    .o_clear_div_en (clear_div_en)
  );

  // detector or run bit starts oscillator
  assign o_fallback_oscillator_en = user_options_two_reg[BIT_RUN_OSC] | (user_options_two_reg[BIT_DETECT_EN] & low_rate_sync_reg[1]);

  // force dc bit out; stored dc values drive out whatever force dc is
  assign o_dc_force      = qb_reg[BIT_FORCE_DC];
  assign o_dc_inphase    = {dci_hi_reg[5:0], dci_lo_reg};
  assign o_dc_quadrature = {dcq_hi_reg[5:0], dcq_lo_reg};

  assign o_nsr_on   = nsr_reg[BIT_NSR_ON];
  assign o_nsr_mode = nsr_reg[2:1];

  assign o_assign_a = asg_a_reg[0];
  assign o_assign_b = asg_b_reg[0];
  assign o_overrange_indication_pin_oe_a = ovr_a_reg[0];
  assign o_overrange_indication_pin_oe_b = ovr_b_reg[0];

  // remaining settings straight from flops
  assign o_output_enable_pin_en  = user_options_two_reg[BIT_OE_PIN_EN];
  assign o_sdio_pulldown_dis     = user_options_two_reg[BIT_PULLDN_DIS];
  assign o_patt1_hi_byte         = {patt1_hi_reg, 8'h00};
  assign o_patt2                 = {patt2_hi_reg, patt2_lo_reg};
  assign o_qec_ctrl              = qa_reg[5:0];
  assign o_qec_force             = qb_reg[2:0];
  assign o_gain_bw               = gbw_reg[4:0];
  assign o_phase_bw              = pbw_reg[4:0];
  assign o_dc_loop_time_constant = dbw_reg[4:0];
  assign o_gain_value            = {g_hi_reg[6:0], g_lo_reg};
  assign o_phase_value           = {p_hi_reg[4:0], p_lo_reg};
  assign o_rdata                 = rdata_reg;
  assign o_rvalid                = rvalid_reg;
endmodule // dafrb_regs

// [dafrb_regs_properties.sv]
// checker: port-level properties of the feature register bank
`timescale 1ns/1ps
module dafrb_regs_chk
  import dafrb_pkg::*;
(
  // clock and reset
  input wire logic                         i_clk_sys,
  input wire logic                         i_arst_n,
  // register port
  input wire logic                         i_wr_en,
  input wire logic                         i_rd_en,
  input wire logic [dafrb_pkg::ADDR_W-1:0] i_addr,
  input wire logic [7:0]                   i_wdata,
  input wire logic                         i_chan_sel_a,
  input wire logic                         i_chan_sel_b,
  input wire logic [7:0]                   o_rdata,
  input wire logic                         o_rvalid,
  // watched controls
  input wire logic                         i_sync_pin,
  input wire logic                         o_div_sync,
  input wire logic                         o_assign_a,
  input wire logic                         o_overrange_indication_pin_oe_b,
  input wire logic                         o_dc_force,
  input wire logic [13:0]                  o_dc_inphase,
  input wire logic [13:0]                  o_dc_quadrature,
  input wire logic                         o_nsr_on,
  input wire logic [1:0]                   o_nsr_mode
);
  default clocking cb @(posedge i_clk_sys); endclocking
  default disable iff (!i_arst_n);
  // write strobe at one offset
  sequence wr_hit(logic [8:0] a);
    i_wr_en && i_addr == a;
  endsequence
  // read request answered in the next cycle
  sequence rd_answer;
    i_rd_en ##1 o_rvalid;
  endsequence
  chk_read_answer: assert property (i_rd_en |-> rd_answer) else $error("read not answered");
  chk_rvalid_spur: assert property (!i_rd_en |=> !o_rvalid) else $error("valid without read");
  chk_rdata_holds: assert property (!i_rd_en |=> $stable(o_rdata)) else $error("read data moved");
  chk_nsr_field: assert property (
    wr_hit(OFS_NSR_CTRL) |=> {o_nsr_mode, o_nsr_on} == $past(i_wdata[2:0])) else $error("nsr field");
  chk_dci_low: assert property (
    wr_hit(OFS_DCI_LO) |=> o_dc_inphase[7:0] == $past(i_wdata)) else $error("dc i low byte");
  chk_dcq_high: assert property (
    wr_hit(OFS_DCQ_HI) |=> o_dc_quadrature[13:8] == $past(i_wdata[5:0])) else $error("dc q high");
  chk_assign_chan_a: assert property (
    wr_hit(OFS_OUT_ASSIGN) ##0 i_chan_sel_a |=> o_assign_a == $past(i_wdata[0])) else $error("assign a");
  chk_ovr_oe_b: assert property (
    wr_hit(OFS_OVR_FEAT) ##0 i_chan_sel_b |=> o_overrange_indication_pin_oe_b == $past(i_wdata[0]))
    else $error("overrange enable b");
  chk_force_dc: assert property (
    wr_hit(OFS_QEC_CTRL_B) |=> o_dc_force == $past(i_wdata[2])) else $error("force dc");
  chk_sync_cause: assert property (o_div_sync |-> $past(i_sync_pin, 3)) else $error("sync w/o pin");
  chk_sync_single: assert property (o_div_sync |=> !o_div_sync) else $error("sync pulse too long");
endmodule // dafrb_regs_chk

bind dafrb_regs dafrb_regs_chk u_chk (.i_clk_sys, .i_arst_n, .i_wr_en, .i_rd_en, .i_addr, .i_wdata,
  .i_chan_sel_a, .i_chan_sel_b, .o_rdata, .o_rvalid, .i_sync_pin, .o_div_sync, .o_assign_a,
  .o_overrange_indication_pin_oe_b, .o_dc_force, .o_dc_inphase, .o_dc_quadrature, .o_nsr_on, .o_nsr_mode);

// [dafrb_host_model.sv]
// host model: serial decoder side of the register port
`timescale 1ns/1ps
module dafrb_host_model (
  // clock
  input  wire logic       i_clk_sys,
  // answer from the bank
  input  wire logic [7:0] i_rdata,
  input  wire logic       i_rvalid,
  // requests
  output logic            o_wr_en,
  output logic            o_rd_en,
  output logic [8:0]      o_addr,
  output logic [7:0]      o_wdata
);
  // idle lines carry junk, never a stale request
  initial begin
    o_wr_en = 1'b0;
    o_rd_en = 1'b0;
    o_addr  = 9'h0aa;
    o_wdata = 8'h55;
  end
  // one byte write; released lines show inverted values
  task automatic wr(input logic [8:0] a, input logic [7:0] d);
    @(posedge i_clk_sys);
    #1 o_wr_en = 1'b1;
    o_addr  = a;
    o_wdata = d;
    @(posedge i_clk_sys);
    #1 o_wr_en = 1'b0;
    o_addr  = ~a;
    o_wdata = ~d;
  endtask
  // one byte read; answer taken just after the request edge
  task automatic rd(input logic [8:0] a, output logic [7:0] q, output logic v);
    @(posedge i_clk_sys);
    #1 o_rd_en = 1'b1;
    o_addr  = a;
    @(posedge i_clk_sys);
    #1 o_rd_en = 1'b0;
    o_addr  = ~a;
    q = i_rdata;
    v = i_rvalid;
  endtask
endmodule // dafrb_host_model

// [tb_top.sv]
// testbench: register bank access, reset values and control outputs
`timescale 1ns/1ps
module tb_top;
  import dafrb_pkg::*;
  // clock, reset, counters
  logic i_clk_sys, i_arst_n;
  int   miscompares = 0, total_checks = 0, cycles = 0, pulses = 0;
  // design ports
  logic        i_wr_en, i_rd_en, i_chan_sel_a, i_chan_sel_b, o_rvalid, i_low_rate_pin, i_sync_pin, v;
  logic [8:0]  i_addr;
  logic [7:0]  i_wdata, o_rdata, i_signature_lo, q;
  logic        o_assign_a, o_assign_b, oe_a, oe_b, oe_pin, pd_dis, osc, o_div_sync, o_dc_force, o_nsr_on;
  logic [1:0]  o_nsr_mode;
  logic [13:0] o_dc_inphase, o_dc_quadrature;
  logic [15:0] patt1, patt2;
  logic [5:0]  qctl;
  logic [2:0]  qfrc;
  logic [4:0]  gbw, pbw, dbw;
  logic [14:0] gval;
  logic [12:0] pval;
  // offsets, reset values and used-bit masks
  localparam logic [8:0] AD [20] = '{9'h01a, 9'h01b, 9'h01c, 9'h02a, 9'h100, 9'h101, 9'h110, 9'h111,
    9'h112, 9'h113, 9'h114, 9'h116, 9'h117, 9'h118, 9'h119, 9'h11a, 9'h11b, 9'h11c, 9'h11d, 9'h11e};
  localparam logic [7:0] RV [20] = '{8'h00, 8'h00, 8'h00, 8'h01, 8'h01, 8'h88, 8'h00, 8'h00, 8'h02,
    8'h02, 8'h02, 8'h00, 8'h00, 8'h00, 8'h00, 8'h00, 8'h00, 8'h00, 8'h00, 8'h00};
  localparam logic [7:0] MK [20] = '{8'hff, 8'hff, 8'hff, 8'h01, 8'h07, 8'h8d, 8'h3f, 8'h07, 8'h1f,
    8'h1f, 8'h1f, 8'hff, 8'h7f, 8'hff, 8'h1f, 8'hff, 8'h3f, 8'hff, 8'h3f, 8'h07};

  dafrb_regs uut (.i_clk_sys, .i_arst_n, .i_wr_en, .i_rd_en, .i_addr, .i_wdata, .i_chan_sel_a,
    .i_chan_sel_b, .o_rdata, .o_rvalid, .i_signature_lo, .i_low_rate_pin, .i_sync_pin, .o_assign_a,
    .o_assign_b, .o_overrange_indication_pin_oe_a(oe_a), .o_overrange_indication_pin_oe_b(oe_b),
    .o_output_enable_pin_en(oe_pin), .o_sdio_pulldown_dis(pd_dis), .o_fallback_oscillator_en(osc),
    .o_div_sync, .o_patt1_hi_byte(patt1), .o_patt2(patt2), .o_qec_ctrl(qctl), .o_qec_force(qfrc),
    .o_gain_bw(gbw), .o_phase_bw(pbw), .o_dc_loop_time_constant(dbw), .o_gain_value(gval),
    .o_phase_value(pval), .o_dc_force,
    .o_dc_inphase, .o_dc_quadrature, .o_nsr_on, .o_nsr_mode);
  dafrb_host_model host (.i_clk_sys, .i_rdata(o_rdata), .i_rvalid(o_rvalid), .o_wr_en(i_wr_en),
    .o_rd_en(i_rd_en), .o_addr(i_addr), .o_wdata(i_wdata));

  // compare and count
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    total_checks++;
    if (got !== exp) begin
      miscompares++;
      $display("[ERR] t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  // read one byte and compare
  task automatic rdchk(input logic [8:0] a, input logic [7:0] e);
    host.rd(a, q, v);
    chk(v, 1'b1);
    chk(q, e);
  endtask
  // one sync pin pulse, long enough to pass the synchronisers
  task automatic sync_pulse;
    @(posedge i_clk_sys);
    #1 i_sync_pin = 1'b1;
    repeat (8) @(posedge i_clk_sys);
    #1 i_sync_pin = 1'b0;
    repeat (8) @(posedge i_clk_sys);
  endtask
  task automatic tally_and_finish;
    $display("checks=%0d mismatches=%0d", total_checks, miscompares);
    if (miscompares == 0 && total_checks > 0)
      $display("Run complete: PASS");
    else
      $display("Run complete: FAIL");
    $finish;
  endtask

  initial begin
    i_clk_sys = 1'b0;
    forever #4 i_clk_sys = ~i_clk_sys;
  end
  // divider pulse count and hang guard
  always @(posedge i_clk_sys) begin
    cycles <= cycles + 1;
    if (o_div_sync === 1'b1) pulses <= pulses + 1;
    if (cycles == 3000) begin
      miscompares = miscompares + 1;
      tally_and_finish();
    end
  end

  initial begin
    i_arst_n = 1'b0;
    i_chan_sel_a = 1'b1;
    i_chan_sel_b = 1'b1;
    i_signature_lo = 8'h5a;
    i_low_rate_pin = 1'b0;
    i_sync_pin = 1'b0;
    repeat (10) @(posedge i_clk_sys);
    #1 i_arst_n = 1'b1;
    repeat (3) @(posedge i_clk_sys);
    chk({o_assign_a, o_assign_b, oe_a, oe_b, oe_pin, osc}, 6'b011110);
    // reset values, then all-ones keeps only the used bits
    for (int i = 0; i < 20; i++) rdchk(AD[i], RV[i]);
    for (int i = 0; i < 20; i++) host.wr(AD[i], 8'hff);
    for (int i = 0; i < 20; i++) rdchk(AD[i], MK[i]);
    chk({oe_a, oe_b, oe_pin, pd_dis, osc, o_dc_force}, 6'h3f);
    chk({o_nsr_mode, o_nsr_on, o_dc_inphase}, 17'h1ffff);
    chk({patt1, patt2}, 32'hff00ffff);
    chk({qctl, qfrc, gbw, pbw, dbw}, 24'hffffff);
    chk({gval, pval}, 28'hfffffff);
    // read-only signature and an unmapped offset ignore writes
    host.wr(9'h024, 8'h00);
    rdchk(9'h024, 8'h5a);
    host.wr(9'h115, 8'hff);
    rdchk(9'h115, 8'h00);
    // dc initial values split over two bytes
    host.wr(9'h11a, 8'h34);
    host.wr(9'h11b, 8'hd2);
    host.wr(9'h11c, 8'h78);
    host.wr(9'h11d, 8'h56);
    chk({o_dc_inphase, o_dc_quadrature}, {14'h1234, 14'h1678});
    host.wr(9'h111, 8'h03);
    chk(o_dc_force, 1'b0);
    host.wr(9'h111, 8'h04);
    chk(o_dc_force, 1'b1);
    // every requantizer mode, then off
    for (int m = 0; m < 4; m++) begin
      host.wr(9'h11e, {5'h00, m[1:0], 1'b1});
      chk({o_nsr_on, o_nsr_mode}, {1'b1, m[1:0]});
    end
    host.wr(9'h11e, 8'h06);
    chk({o_nsr_on, o_nsr_mode}, 3'b011);
    // per-channel bits follow the channel selects
    i_chan_sel_b = 1'b0;
    host.wr(9'h02e, 8'h00);
    chk({o_assign_a, o_assign_b}, 2'b01);
    i_chan_sel_a = 1'b0;
    i_chan_sel_b = 1'b1;
    host.wr(9'h02a, 8'h00);
    chk({oe_a, oe_b}, 2'b10);
    rdchk(9'h02a, 8'h00);
    rdchk(9'h02e, 8'h01);
    // fallback oscillator: detect needs the low-rate input, run overrides
    host.wr(9'h101, 8'h08);
    chk(osc, 1'b0);
    i_low_rate_pin = 1'b1;
    repeat (3) @(posedge i_clk_sys);
    #1 chk(osc, 1'b1);
    host.wr(9'h101, 8'h80);
    chk(osc, 1'b0);
    host.wr(9'h101, 8'h04);
    chk(osc, 1'b1);
    // sync gated by master enable; next-only clears the divider enable
    host.wr(9'h100, 8'h02);
    sync_pulse();
    chk(pulses, 0);
    host.wr(9'h100, 8'h03);
    sync_pulse();
    sync_pulse();
    chk(pulses, 2);
    host.wr(9'h100, 8'h07);
    sync_pulse();
    sync_pulse();
    chk(pulses, 3);
    rdchk(9'h100, 8'h05);
    tally_and_finish();
  end
endmodule // tb_top
